// ### core/fpc_pkg.sv
// Shared constants and types for the fetch, PC, stack and ALU core.
// Assumes an 11-bit program space of 16-bit words and an 8-bit data space.
package fpc_pkg;

    // ------------------------------------------------------------------
    // Widths and types
    // ------------------------------------------------------------------
    localparam int PC_W   = 11;
    localparam int INST_W = 16;
    localparam int DATA_W = 8;

    typedef logic [PC_W-1:0]   fpc_pc_t;
    typedef logic [INST_W-1:0] fpc_inst_t;
    typedef logic [DATA_W-1:0] fpc_byte_t;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam fpc_pc_t   PC_RESET     = 11'h000;
    localparam fpc_byte_t STATUS_RESET = 8'h00;
    localparam fpc_byte_t BYTE_RESET   = 8'h00;

    // ------------------------------------------------------------------
    // Internal register addresses in data space
    // ------------------------------------------------------------------
    localparam fpc_byte_t ADDR_IND    = 8'h00;  // Indirect through the pointer
    localparam fpc_byte_t ADDR_MPTR   = 8'h01;
    localparam fpc_byte_t ADDR_PCL    = 8'h02;  // pc_low_byte
    localparam fpc_byte_t ADDR_STATUS = 8'h03;
    localparam fpc_byte_t ADDR_SYSCTL = 8'h04;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int ST_C      = 0;
    localparam int ST_AC     = 1;
    localparam int ST_Z      = 2;
    localparam int ST_OV     = 3;
    localparam int ST_EMI    = 4;
    localparam int CTL_SLOW  = 0;
    localparam int IR_DEST   = 10;  // 1: result to memory, 0: to accumulator
    localparam int IR_ALU    = 15;  // Top opcode bit marks an ALU operation

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_T1 = 2'b00,
        PH_T2 = 2'b01,
        PH_T3 = 2'b10,
        PH_T4 = 2'b11
    } fpc_phase_t;

    typedef enum logic [3:0] {
        ALU_ADD = 4'h0, ALU_ADC = 4'h1, ALU_SUB = 4'h2, ALU_SBC = 4'h3,
        ALU_AND = 4'h4, ALU_OR  = 4'h5, ALU_XOR = 4'h6, ALU_CPL = 4'h7,
        ALU_RR  = 4'h8, ALU_RRC = 4'h9, ALU_RL  = 4'hA, ALU_RLC = 4'hB,
        ALU_INC = 4'hC, ALU_DEC = 4'hD, ALU_DAA = 4'hE, ALU_PASS = 4'hF
    } fpc_alu_op_t;

    typedef enum logic [4:0] {
        OP_NOP   = 5'h00, OP_MOVMA = 5'h02, OP_SZ   = 5'h03,
        OP_SNZ   = 5'h04, OP_SIZ   = 5'h05, OP_SDZ  = 5'h06,
        OP_RET   = 5'h07, OP_RETURN_FROM_INTERRUPT  = 5'h08, OP_JMP  = 5'h09,
        OP_CALL  = 5'h0A, OP_MOVAK = 5'h0B
    } fpc_op_t;

endpackage

// ### core/fpc_alu_if.sv
// Operand, result and flag bundle between the core and its ALU.
// Assumes a purely combinational ALU on the alu side.
`timescale 1ns/1ps
interface fpc_alu_if;
    import fpc_pkg::*;
    fpc_alu_op_t op;
    fpc_byte_t   a;
    fpc_byte_t   b;
    logic        c_in;
    logic        ac_in;
    logic        ov_in;
    fpc_byte_t   y;
    logic        c_out;
    logic        ac_out;
    logic        ov_out;
    logic        z;

    modport core (output op, a, b, c_in, ac_in, ov_in, input y, c_out, ac_out, ov_out, z);
    modport alu  (input op, a, b, c_in, ac_in, ov_in, output y, c_out, ac_out, ov_out, z);
endinterface

// ### core/fpc_alu.sv
// Eight-bit ALU: arithmetic, logic, rotate, increment and decimal adjust.
// Assumes operand a is the accumulator and b the addressed data operand.
`timescale 1ns/1ps
module fpc_alu (
    fpc_alu_if.alu bus  // Operands in, result and flags out
);
    import fpc_pkg::*;

    logic [8:0] sum;
    logic [4:0] lo;
    logic [7:0] bx;
    logic       ci;
    logic [8:0] adj;

    // Shared adder; subtract is add of the inverse, carry set means no borrow
    always_comb begin
        bx  = (bus.op == ALU_SUB || bus.op == ALU_SBC) ? ~bus.b : bus.b;
        ci  = (bus.op == ALU_SUB) ? 1'b1 : ((bus.op == ALU_ADD) ? 1'b0 : bus.c_in);
        sum = {1'b0, bus.a} + {1'b0, bx} + {8'h00, ci};
        lo  = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
        adj = {1'b0, bus.a};
        if (bus.a[3:0] > 4'h9 || bus.ac_in) begin
            adj = adj + 9'h006;
        end
        if (adj[7:4] > 4'h9 || bus.c_in || adj[8]) begin
            adj = adj + 9'h060;
        end
        bus.c_out  = bus.c_in;
        bus.ac_out = bus.ac_in;
        bus.ov_out = bus.ov_in;
        unique case (bus.op)
            ALU_ADD, ALU_ADC, ALU_SUB, ALU_SBC: begin
                bus.y      = sum[7:0];
                bus.c_out  = sum[8];
                bus.ac_out = lo[4];
                bus.ov_out = (bus.a[7] == bx[7]) && (sum[7] != bus.a[7]);
            end
            ALU_AND: bus.y = bus.a & bus.b;
            ALU_OR:  bus.y = bus.a | bus.b;
            ALU_XOR: bus.y = bus.a ^ bus.b;
            ALU_CPL: bus.y = ~bus.b;
            ALU_RR:  bus.y = {bus.b[0], bus.b[7:1]};
            ALU_RRC: begin
                bus.y     = {bus.c_in, bus.b[7:1]};
                bus.c_out = bus.b[0];
            end
            ALU_RL:  bus.y = {bus.b[6:0], bus.b[7]};
            ALU_RLC: begin
                bus.y     = {bus.b[6:0], bus.c_in};
                bus.c_out = bus.b[7];
            end
            ALU_INC: bus.y = bus.b + 8'h01;
            ALU_DEC: bus.y = bus.b - 8'h01;
            ALU_DAA: begin
                bus.y     = adj[7:0];
                bus.c_out = adj[8] | bus.c_in;
            end
            ALU_PASS: bus.y = bus.b;
        endcase
        bus.z = (bus.y == 8'h00);
    end

endmodule

// ### core/fpc_core.sv
// Instruction sequencer: four-phase timing, two-stage fetch/execute pipe,
// 11-bit program counter, hidden return stack, ALU and internal registers.
// Assumes program and data memories answer a read strobe one cycle later.
//
// Functional notes
// - Four phases form one instruction cycle
// - PC advances at first phase with fetch
// - Fetch overlaps execute, one per cycle
// - Jumps and calls flush, cost one cycle
// - Taken skip discards prefetch, runs dummy cycle
// - PC is 3 high bits plus low byte
// - PC increments unless a transfer happens
// - Only PC low byte is software visible
// - Low byte write jumps within 256-word page
// - Low byte branch inserts one dummy cycle
// - Jump, call, interrupt, reset load target
// - Stack holds PCs, hidden from software
// - Call or interrupt acknowledge pushes return PC
// - Return pops stack into PC
// - Reset leaves stack empty
// - Full stack holds interrupt until return
// - Call on full stack overwrites oldest
// - Eight-bit ALU writes result, updates flags
// - ALU add, sub, logic, rotate, inc, DAA
// - Phase clock selectable fast or slow
// - Operands via accumulator; direct and indirect
`timescale 1ns/1ps
module fpc_core #(
    parameter int               STACK_DEPTH = 8,       // Return stack levels
    parameter fpc_pkg::fpc_pc_t INT_VECTOR  = 11'h004  // Interrupt entry
) (
    input  wire logic               mclk,          // System clock
    input  wire logic               reset,         // Synchronous, active high
    input  wire logic               slow_tick,     // Slow RC oscillator tick
    output logic                    fast_osc_sel,  // High: fast RC drives phases
    output fpc_pkg::fpc_phase_t     clock_phases,  // Current phase
    output fpc_pkg::fpc_pc_t        pm_addr,       // Program memory address
    output logic                    pm_rd,         // Program read strobe
    input  wire fpc_pkg::fpc_inst_t pm_data,       // Word, cycle after strobe
    output fpc_pkg::fpc_byte_t      dm_addr,       // Data memory address
    output fpc_pkg::fpc_byte_t      dm_wdata,      // Data memory write data
    output logic                    dm_wr,         // Data write strobe
    output logic                    dm_rd,         // Data read strobe
    input  wire fpc_pkg::fpc_byte_t dm_rdata,      // Byte, cycle after strobe
    input  wire logic               irq_req,       // Enabled request pending
    output logic                    irq_ack,       // Acknowledge pulse
    output logic                    stack_full     // Stack at full depth
);
    import fpc_pkg::*;

    localparam int SPW = (STACK_DEPTH > 1) ? $clog2(STACK_DEPTH) : 1;

    fpc_phase_t        phase;
    fpc_pc_t           pc, fetch_pc, ir_pc, ret_pc, stk_top, push_val;
    fpc_inst_t         ir, fetch_buf;
    fpc_byte_t         acc, mptr, opnd, ea, ea_q, int_val, wdata, status;
    fpc_pc_t           stk [STACK_DEPTH];
    logic [SPW-1:0]    wp, wp_inc, wp_dec;
    logic [SPW:0]      count;
    fpc_op_t           op;
    logic              step, slow_sel, ir_valid, pm_rd_q, dm_rd_q;
    logic              is_alu, dest_mem, is_sxz, exec, wr_res, ea_int, ea_int_q;
    logic              skip_now, pcl_jump, call, unconditional_branch, ret, flush_br, int_take;
    logic              flush, push, pop;

    fpc_alu_if alu_bus();

    fpc_alu u_alu (
        .bus (alu_bus)
    );

    // ------------------------------------------------------------------
    // Phase generator
    // ------------------------------------------------------------------
    // Slow mode only advances on ticks of the slow oscillator
    assign step         = slow_sel ? slow_tick : 1'b1;
    assign fast_osc_sel = ~slow_sel;
    assign clock_phases = phase;

    always_ff @(posedge mclk) begin
        if (reset) begin
            phase <= PH_T1;
        end else if (step) begin
            unique case (phase)
                PH_T1: phase <= PH_T2;
                PH_T2: phase <= PH_T3;
                PH_T3: phase <= PH_T4;
                PH_T4: phase <= PH_T1;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Decode of the executing instruction
    // ------------------------------------------------------------------
    assign op       = fpc_op_t'(ir[15:11]);
    assign is_alu   = ir[IR_ALU];
    assign dest_mem = ir[IR_DEST];
    assign is_sxz   = !is_alu && (op == OP_SIZ || op == OP_SDZ);
    assign exec     = step && phase == PH_T4 && ir_valid;
    assign wr_res   = (is_alu || is_sxz) ? dest_mem : (op == OP_MOVMA);
    assign ret_pc   = ir_pc + 11'h001;
    // Indirect access goes through the memory pointer
    assign ea       = (ir[7:0] == ADDR_IND) ? mptr : ir[7:0];
    assign ea_int   = (ea <= ADDR_SYSCTL);
    assign wdata    = (!is_alu && op == OP_MOVMA) ? acc : alu_bus.y;

    // Control transfers, each evaluated only in the execute phase
    assign call     = exec && !is_alu && op == OP_CALL;
    assign unconditional_branch      = exec && !is_alu && op == OP_JMP;
    assign ret      = exec && !is_alu && (op == OP_RET || op == OP_RETURN_FROM_INTERRUPT);
    assign pcl_jump = exec && wr_res && ea_int_q && ea_q == ADDR_PCL;
    assign skip_now = exec && !is_alu && ((op == OP_SZ && alu_bus.z) ||
                      (op == OP_SNZ && !alu_bus.z) || (is_sxz && alu_bus.z));
    assign flush_br = call || unconditional_branch || ret || pcl_jump || skip_now;
    // Interrupts wait for a boundary that does not itself redirect the PC
    assign int_take = step && phase == PH_T4 && irq_req && status[ST_EMI]
                      && !stack_full && !flush_br;
    assign flush    = flush_br || int_take;

    // ------------------------------------------------------------------
    // ALU hookup
    // ------------------------------------------------------------------
    assign alu_bus.op    = is_alu ? fpc_alu_op_t'(ir[14:11]) :
                           (!is_sxz ? ALU_PASS : (op == OP_SIZ ? ALU_INC : ALU_DEC));
    assign alu_bus.a     = acc;
    assign alu_bus.b     = opnd;
    assign alu_bus.c_in  = status[ST_C];
    assign alu_bus.ac_in = status[ST_AC];
    assign alu_bus.ov_in = status[ST_OV];

    // ------------------------------------------------------------------
    // Program counter
    // ------------------------------------------------------------------
    // Only one transfer source can be active per execute phase
    always_ff @(posedge mclk) begin
        if (reset) begin
            pc <= PC_RESET;
        end else if (call || unconditional_branch) begin
            pc <= ir[10:0];
        end else if (int_take) begin
            pc <= INT_VECTOR;
        end else if (ret) begin
            pc <= stk_top;
        end else if (pcl_jump) begin
            pc <= {pc[10:8], wdata};
        end else if (step && phase == PH_T1) begin
            pc <= pc + 11'h001;
        end
    end

    // ------------------------------------------------------------------
    // Fetch stage
    // ------------------------------------------------------------------
    // Next word is fetched while the current one executes
    always_ff @(posedge mclk) begin
        if (reset) begin
            pm_addr   <= PC_RESET;
            fetch_pc  <= PC_RESET;
            pm_rd     <= 1'b0;
            pm_rd_q   <= 1'b0;
            fetch_buf <= '0;
        end else begin
            pm_rd   <= step && phase == PH_T1;
            pm_rd_q <= pm_rd;
            if (step && phase == PH_T1) begin
                pm_addr  <= pc;
                fetch_pc <= pc;
            end
            if (pm_rd_q) begin
                fetch_buf <= pm_data;
            end
        end
    end

    // Word moves into execute at the cycle boundary; a flush voids it
    always_ff @(posedge mclk) begin
        if (reset) begin
            ir       <= '0;
            ir_pc    <= PC_RESET;
            ir_valid <= 1'b0;
        end else if (step && phase == PH_T4) begin
            ir       <= fetch_buf;
            ir_pc    <= fetch_pc;
            ir_valid <= !flush;
        end
    end

    // ------------------------------------------------------------------
    // Operand read and result write
    // ------------------------------------------------------------------
    // Internal registers; the PC high bits are never readable here
    always_comb begin
        unique case (ea_q)
            ADDR_MPTR:   int_val = mptr;
            ADDR_PCL:    int_val = ret_pc[7:0];
            ADDR_STATUS: int_val = status;
            ADDR_SYSCTL: int_val = {7'h00, slow_sel};
            default:     int_val = BYTE_RESET;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            dm_addr  <= BYTE_RESET;
            dm_wdata <= BYTE_RESET;
            dm_rd    <= 1'b0;
            dm_wr    <= 1'b0;
            dm_rd_q  <= 1'b0;
            ea_q     <= BYTE_RESET;
            ea_int_q <= 1'b0;
            opnd     <= BYTE_RESET;
        end else begin
            dm_rd   <= step && phase == PH_T1 && ir_valid && !ea_int;
            dm_rd_q <= dm_rd;
            dm_wr   <= exec && wr_res && !ea_int_q;
            if (step && phase == PH_T1) begin
                dm_addr  <= ea;
                ea_q     <= ea;
                ea_int_q <= ea_int;
            end
            if (exec) begin
                dm_wdata <= wdata;
            end
            if (dm_rd_q) begin
                opnd <= dm_rdata;
            end else if (step && phase == PH_T3 && ea_int_q) begin
                opnd <= int_val;
            end
        end
    end

    // ------------------------------------------------------------------
    // Accumulator, pointer, control and status
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (reset) begin
            acc <= BYTE_RESET;
        end else if (exec && !is_alu && op == OP_MOVAK) begin
            acc <= ir[7:0];
        end else if (exec && (is_alu || is_sxz) && !dest_mem) begin
            acc <= alu_bus.y;
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            mptr     <= BYTE_RESET;
            slow_sel <= 1'b0;
        end else if (exec && wr_res && ea_int_q) begin
            if (ea_q == ADDR_MPTR) begin
                mptr <= wdata;
            end
            if (ea_q == ADDR_SYSCTL) begin
                slow_sel <= wdata[CTL_SLOW];
            end
        end
    end

    // A direct write to status wins over the ALU's own flag update
    always_ff @(posedge mclk) begin
        if (reset) begin
            status <= STATUS_RESET;
        end else begin
            if (exec && wr_res && ea_int_q && ea_q == ADDR_STATUS) begin
                status <= wdata;
            end else if (exec && (is_alu || is_sxz)) begin
                status[ST_C]  <= alu_bus.c_out;
                status[ST_AC] <= alu_bus.ac_out;
                status[ST_Z]  <= alu_bus.z;
                status[ST_OV] <= alu_bus.ov_out;
            end else if (exec && op == OP_SZ) begin
                status[ST_Z] <= alu_bus.z;
            end
            if (int_take) begin
                status[ST_EMI] <= 1'b0;
            end else if (ret && op == OP_RETURN_FROM_INTERRUPT) begin
                status[ST_EMI] <= 1'b1;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_ack <= 1'b0;
        end else begin
            irq_ack <= int_take;
        end
    end

    // ------------------------------------------------------------------
    // Return stack
    // ------------------------------------------------------------------
    // Circular store: a push when full overwrites the oldest entry
    assign push       = call || int_take;
    assign pop        = ret;
    assign push_val   = call ? ret_pc : fetch_pc;
    assign wp_inc     = (wp == SPW'(STACK_DEPTH - 1)) ? '0 : wp + 1'b1;
    assign wp_dec     = (wp == '0) ? SPW'(STACK_DEPTH - 1) : wp - 1'b1;
    assign stk_top    = stk[wp_dec];
    assign stack_full = (count == (SPW + 1)'(STACK_DEPTH));

    always_ff @(posedge mclk) begin
        if (reset) begin
            wp    <= '0;
            count <= '0;
        end else if (push) begin
            wp <= wp_inc;
            if (!stack_full) begin
                count <= count + 1'b1;
            end
        end else if (pop && count != '0) begin
            wp    <= wp_dec;
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (push) begin
            stk[wp] <= push_val;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_phase_wrap:
    assert property (@(posedge mclk) disable iff (reset) (step && phase == PH_T4) |=> phase == PH_T1)
        else $error("phase did not wrap to T1");
    a_phase_hold:
    assert property (@(posedge mclk) disable iff (reset) !step |=> $stable(phase))
        else $error("phase moved without a step");
    a_pc_fetch:
    assert property (@(posedge mclk) disable iff (reset)
        (step && phase == PH_T1 && !$past(reset)) |=> pm_rd && pm_addr == $past(pc) && pc == $past(pc) + 11'h001)
        else $error("fetch did not advance the pc");
    a_fetch_capture:
    assert property (@(posedge mclk) disable iff (reset) pm_rd |=> pm_rd_q ##1 fetch_buf == $past(pm_data))
        else $error("fetched word not captured");
    a_branch_flush:
    assert property (@(posedge mclk) disable iff (reset) (call || unconditional_branch) |=> pc == $past(ir[10:0]) && !ir_valid)
        else $error("branch did not load target and flush");
    a_skip_dummy:
    assert property (@(posedge mclk) disable iff (reset) skip_now |=> !ir_valid)
        else $error("taken skip left prefetch valid");
    a_pcl_page:
    assert property (@(posedge mclk) disable iff (reset)
        pcl_jump |=> pc[10:8] == $past(pc[10:8]) && pc[7:0] == $past(wdata) && !ir_valid)
        else $error("low byte jump left page or missed dummy");
    a_stack_empty:
    assert property (@(posedge mclk) reset |=> count == '0 && !stack_full)
        else $error("stack not empty after reset");
    a_irq_hold:
    assert property (@(posedge mclk) disable iff (reset) stack_full |=> !irq_ack)
        else $error("interrupt taken on full stack");
    a_irq_vector:
    assert property (@(posedge mclk) disable iff (reset)
        int_take |=> irq_ack && pc == INT_VECTOR && !ir_valid && stk_top == $past(fetch_pc))
        else $error("interrupt did not push and vector");
    a_ret_restore:
    assert property (@(posedge mclk) disable iff (reset) ret |=> pc == $past(stk_top) && !ir_valid)
        else $error("return did not restore pc");
    a_call_overflow:
    assert property (@(posedge mclk) disable iff (reset) (call && stack_full) |=> stack_full && wp == $past(wp_inc))
        else $error("call on full stack misbehaved");

endmodule

// ### test/fpc_mem_model.sv
// Program and data memory model facing the core's fetch and data ports.
// Assumes reads answer in the cycle after the strobe and never stall.
`timescale 1ns/1ps
module fpc_mem_model
    import fpc_pkg::*;
(
    input  wire logic      mclk,     // System clock
    input  wire fpc_pc_t   pm_addr,  // Program address
    input  wire logic      pm_rd,    // Program read strobe
    output fpc_inst_t      pm_data,  // Program word
    input  wire fpc_byte_t dm_addr,  // Data address
    input  wire fpc_byte_t dm_wdata, // Data write value
    input  wire logic      dm_wr,    // Data write strobe
    input  wire logic      dm_rd,    // Data read strobe
    output fpc_byte_t      dm_rdata  // Data read value
);
    fpc_inst_t pmem [0:2047];
    fpc_byte_t dmem [0:255];

    // ------------------------------------------------------------------
    // Answers
    // ------------------------------------------------------------------
    // Outside an answer cycle the lines toggle, so a sample one cycle late gets the complement
    initial pm_data = 16'h0000;
    initial dm_rdata = 8'h00;
    always @(posedge mclk) begin
        pm_data <= pm_rd ? pmem[pm_addr] : ~pm_data;
        dm_rdata <= dm_rd ? dmem[dm_addr] : ~dm_rdata;
        if (dm_wr) begin
            dmem[dm_addr] <= dm_wdata;
        end
    end
endmodule

// ### test/fpc_core_tb.sv
// Self-checking bench for the fetch, PC and stack core.
// Assumes the memory model preloaded by hierarchy before each reset.
`timescale 1ns/1ps
module fpc_core_tb;
    import fpc_pkg::*;
    logic       mclk = 0, reset = 1, slow_tick = 0, irq_req = 0;
    logic       fast_osc_sel, pm_rd, dm_wr, dm_rd, irq_ack, stack_full, seen_full;
    fpc_phase_t clock_phases, ack_ph;
    fpc_pc_t    pm_addr;
    fpc_inst_t  pm_data;
    fpc_byte_t  dm_addr, dm_wdata, dm_rdata;
    int         error_cnt = 0, compares = 0, ack_cnt = 0;
    fpc_pc_t    fq[$];
    logic [15:0] wq[$];
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("wrong value %s exp %h got %h", nm, e, g); end end

    fpc_core #(.STACK_DEPTH(2)) u_dut (.mclk(mclk), .reset(reset), .slow_tick(slow_tick),
        .fast_osc_sel(fast_osc_sel), .clock_phases(clock_phases), .pm_addr(pm_addr), .pm_rd(pm_rd),
        .pm_data(pm_data), .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_wr(dm_wr), .dm_rd(dm_rd),
        .dm_rdata(dm_rdata), .irq_req(irq_req), .irq_ack(irq_ack), .stack_full(stack_full));
    fpc_mem_model u_mem (.mclk(mclk), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data),
        .dm_addr(dm_addr), .dm_wdata(dm_wdata), .dm_wr(dm_wr), .dm_rd(dm_rd), .dm_rdata(dm_rdata));

    // ------------------------------------------------------------------
    // Clock and port logging
    // ------------------------------------------------------------------
    initial forever #2 mclk = ~mclk;
    always @(posedge mclk) begin
        if (pm_rd === 1'b1) fq.push_back(pm_addr);
        if (dm_wr === 1'b1) wq.push_back({dm_addr, dm_wdata});
        if (stack_full === 1'b1) seen_full = 1'b1;
        if (irq_ack === 1'b1) begin
            ack_cnt++;
            ack_ph = clock_phases;
        end
    end

    // Reset for five cycles, then let the program run a fixed span
    task restart(input int cyc);
        reset <= 1'b1;
        repeat (5) @(posedge mclk);
        reset <= 1'b0;
        fq.delete();
        wq.delete();
        seen_full = 1'b0;
        ack_cnt = 0;
        repeat (cyc) @(posedge mclk);
    endtask

    task check_fetch(input fpc_pc_t e[$]);
        for (int i = 0; i < e.size(); i++) `CHK("fetch", e[i], fq[i])
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Straight code, ALU to memory, call/return, jump, low-byte write, skip
    task pipe_flow;
        u_mem.pmem[11'h000] = 16'h585A; u_mem.pmem[11'h001] = 16'h1010;
        u_mem.pmem[11'h002] = 16'h8411; u_mem.pmem[11'h003] = 16'h5020;
        u_mem.pmem[11'h020] = 16'h3800; u_mem.pmem[11'h004] = 16'h4900;
        u_mem.pmem[11'h100] = 16'h5805; u_mem.pmem[11'h101] = 16'h1002;
        u_mem.pmem[11'h105] = 16'h1812; u_mem.pmem[11'h106] = 16'h1013;
        u_mem.pmem[11'h107] = 16'h1014; u_mem.pmem[11'h108] = 16'h4908;
        u_mem.dmem[8'h11] = 8'h01; u_mem.dmem[8'h12] = 8'h00;
        restart(80);
        `CHK("fast_sel", 1'b1, fast_osc_sel)
        check_fetch('{11'h000, 11'h001, 11'h002, 11'h003, 11'h004, 11'h020, 11'h021, 11'h004, 11'h005,
            11'h100, 11'h101, 11'h102, 11'h105, 11'h106, 11'h107, 11'h108, 11'h109, 11'h108});
        `CHK("wcount", 3, wq.size())
        `CHK("write0", 16'h105A, wq[0])
        `CHK("write1", 16'h115B, wq[1])
        `CHK("write2", 16'h1405, wq[2])
    endtask

    // Three nested calls on a two-level stack, then unwind
    task stack_overflow;
        u_mem.pmem[11'h000] = 16'h5010; u_mem.pmem[11'h010] = 16'h5020;
        u_mem.pmem[11'h020] = 16'h5030; u_mem.pmem[11'h030] = 16'h3800;
        u_mem.pmem[11'h021] = 16'h3800; u_mem.pmem[11'h011] = 16'h4811;
        restart(48);
        check_fetch('{11'h000, 11'h001, 11'h010, 11'h011, 11'h020, 11'h021, 11'h030, 11'h031,
            11'h021, 11'h022, 11'h011});
        `CHK("full_seen", 1'b1, seen_full)
        `CHK("full_now", 1'b0, stack_full)
    endtask

    // Request held while the stack is full, taken after a return, then slow phases
    task irq_flow;
        u_mem.pmem[11'h020] = 16'h5810;
        u_mem.pmem[11'h021] = 16'h1003;
        u_mem.pmem[11'h022] = 16'h3800;
        u_mem.pmem[11'h004] = 16'h5801;
        u_mem.pmem[11'h005] = 16'h1004;
        u_mem.pmem[11'h006] = 16'h4806;
        irq_req <= 1'b1;
        restart(56);
        check_fetch('{11'h000, 11'h001, 11'h010, 11'h011, 11'h020, 11'h021, 11'h022, 11'h023,
            11'h011, 11'h004, 11'h005, 11'h006});
        `CHK("ack_cnt", 1, ack_cnt)
        `CHK("ack_phase", PH_T1, ack_ph)
        `CHK("full_irq", 1'b1, stack_full)
        `CHK("fast_sel", 1'b0, fast_osc_sel)
        `CHK("phase_hold", PH_T1, clock_phases)
        slow_tick <= 1'b1;
        @(posedge mclk);
        slow_tick <= 1'b0;
        repeat (3) @(posedge mclk);
        `CHK("phase_step", PH_T2, clock_phases)
        `CHK("slow_fetch", 13, fq.size())
    endtask

    task report_and_stop;
        $display("checks %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 2048; i++) u_mem.pmem[i] = 16'h0000;
        pipe_flow();
        stack_overflow();
        irq_flow();
        report_and_stop();
    end

    // Watchdog well beyond the three short programs
    initial begin
        #4000;
        error_cnt++;
        report_and_stop();
    end
endmodule
